/* hdl/eelog_top.sv */
// edge event logger: per-logger core and two-instance top with register port
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - two identical loggers, each with own control, channels, buffer and flags.
// - each channel logs only its chosen edge; both edges need two channels.
// - each entry stores the selected timer's 32-bit value when logged.
// - logging steps every core clock cycle, else on the selected timer's tick.
// - one event per logger cycle; lowest pending channel wins.
// - losers stay queued; repeat edges on a queued channel are dropped.
// - writing 1 to the clear control empties buffer and clears all flags.
// - sixteen channels, each with source, polarity, debounce and enable.
// - on logger enable, a channel already at its active level logs one event.
// - buffer of 16 fills cyclically and never overwrites unread entries.
// - all 16 entries readable in any order: source, polarity, time stamp.
// - write and read index reset to 0; their difference is the unread count except when full.
// - not-empty flag set while any unread entry is held.
// - watermark flag set when free locations reach the threshold.
// - full flag at 16 unread; no further logging until released.
// - full clears only on clear or when the read index is written with a new value.
// - not-empty triggers the sequencer; flags exported for interrupt, GPIO, DSP.
// - wake control requests the core clock while the buffer is not empty and the core clock is off.
// - control bit 0 enables the logger, reset value 0.
// - timer source field 00 picks timer 1, 01 picks timer 2.
// - watermark flag when free space at or below 4-bit threshold, reset 1.
module eelog_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [eelog_pkg::SRC_NUM-1:0] src,
  input wire logic core_on,
  input wire logic [eelog_pkg::STAMP_W-1:0] timer1_value,
  input wire logic [eelog_pkg::STAMP_W-1:0] timer2_value,
  input wire logic timer1_tick,
  input wire logic timer2_tick,
  input wire logic wr_en,
  input wire logic [eelog_pkg::OFF_W-1:0] idx,
  input wire logic [eelog_pkg::DATA_W-1:0] wdata,
  output logic [eelog_pkg::DATA_W-1:0] rdata,
  output logic ne_flag,
  output logic low_flag,
  output logic full_flag,
  output logic seq_trig,
  output logic wake_req
);
  import eelog_pkg::*;
  logic on_reg;
  logic wake_reg;
  logic [1:0] tsel_reg;
  logic [PTR_W-1:0] wmark_reg;
  logic [NCH-1:0] chen_reg;
  logic [SEL_W-1:0] csel_reg [NCH];
  logic [NCH-1:0] cpol_reg;
  logic [NCH-1:0] cdb_reg;
  logic [SEL_W-1:0] etag_reg [DEPTH];
  logic [DEPTH-1:0] ekind_reg;
  logic [STAMP_W-1:0] etime_reg [DEPTH];
  logic [PTR_W-1:0] wptr_reg;
  logic [PTR_W-1:0] rptr_reg;
  logic full_reg;
  logic ne_reg;
  logic low_reg;
  logic trig_reg;
  logic [NCH-1:0] pend;
  logic [NCH-1:0] grant;
  logic [PTR_W-1:0] win;
  logic log_step;
  logic log_go;
  logic clr;
  logic ptr_wr;
  logic [PTR_W-1:0] rptr_next;
  logic [PTR_W-1:0] wptr_inc;
  logic [PTR_W-1:0] used;
  logic [PTR_W:0] free_cnt;
  logic ne_next;
  logic low_next;
  logic [STAMP_W-1:0] stamp;

  function automatic logic [PTR_W-1:0] first_idx(input logic [NCH-1:0] v);
    logic [PTR_W-1:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = PTR_W'(i);
      end
    end
    return r;
  endfunction : first_idx

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  assign clr = wr_en && idx == OFF_CTRL && wdata[CTRL_CLR_BIT];
  assign ptr_wr = wr_en && idx == OFF_PTR;
  assign rptr_next = ptr_wr ? wdata[PTR_RD_LSB +: PTR_W] : rptr_reg;
  assign stamp = (tsel_reg == TSEL_TIMER2) ? timer2_value : timer1_value;
  // slow mode: without the core clock a logger cycle is one timer tick
  assign log_step = core_on ? 1'b1 : ((tsel_reg == TSEL_TIMER2) ? timer2_tick : timer1_tick);
  assign log_go = log_step && on_reg && !full_reg && |pend && !clr;
  assign grant = log_go ? (pend & (~pend + NCH'(1))) : '0;
  assign win = first_idx(pend);
  assign wptr_inc = wptr_reg + PTR_W'(1);
  // control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_reg <= 1'b0;
      wake_reg <= 1'b0;
      tsel_reg <= TSEL_TIMER1;
      wmark_reg <= WMARK_RESET;
      chen_reg <= '0;
    end else if (wr_en) begin
      if (idx == OFF_CTRL) begin
        on_reg <= wdata[CTRL_ON_BIT];
        wake_reg <= wdata[CTRL_WAKE_BIT];
      end else if (idx == OFF_TSEL) begin
        tsel_reg <= wdata[1:0];
      end else if (idx == OFF_WMARK) begin
        wmark_reg <= wdata[PTR_W-1:0];
      end else if (idx == OFF_CHEN) begin
        chen_reg <= wdata[NCH-1:0];
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic raw;
      logic filt_reg;
      logic prev_reg;
      logic pend_reg;
      logic [DB_W-1:0] cnt_reg;
      logic hit;
      assign raw = (csel_reg[c] < SEL_LIMIT) ? src[csel_reg[c][SRC_W-1:0]] : 1'b0;
      // an edge needs both the filtered level and the remembered level
      assign hit = cpol_reg[c] ? (prev_reg && !filt_reg) : (filt_reg && !prev_reg);
      assign pend[c] = pend_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          csel_reg[c] <= '0;
          cpol_reg[c] <= 1'b0;
          cdb_reg[c] <= 1'b0;
        end else if (wr_en && idx == OFF_CHDEF + OFF_W'(2 * c)) begin
          csel_reg[c] <= wdata[SEL_W-1:0];
          cpol_reg[c] <= wdata[DEF_POL_BIT];
          cdb_reg[c] <= wdata[DEF_DB_BIT];
        end
      end
      // debounce: level must hold four samples before it is taken
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          filt_reg <= 1'b0;
          cnt_reg <= '0;
        end else if (!cdb_reg[c] || raw == filt_reg) begin
          filt_reg <= cdb_reg[c] ? filt_reg : raw;
          cnt_reg <= '0;
        end else if (cnt_reg == DB_LAST) begin
          filt_reg <= raw;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg + DB_W'(1);
        end
      end
      // while off, park at the inactive level so an active input logs on enable
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg <= 1'b0;
        end else if (!on_reg) begin
          prev_reg <= cpol_reg[c];
        end else begin
          prev_reg <= filt_reg;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_reg <= 1'b0;
        end else if (clr) begin
          pend_reg <= 1'b0;
        end else if (hit && on_reg && chen_reg[c] && !full_reg) begin
          pend_reg <= 1'b1;
        end else if (grant[c]) begin
          pend_reg <= 1'b0;
        end
      end
    end
  endgenerate

  // buffer entries
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        etag_reg[i] <= '0;
        etime_reg[i] <= '0;
      end
      ekind_reg <= '0;
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) begin
        etag_reg[i] <= '0;
        etime_reg[i] <= '0;
      end
      ekind_reg <= '0;
    end else if (log_go) begin
      etag_reg[wptr_reg] <= csel_reg[win];
      ekind_reg[wptr_reg] <= cpol_reg[win];
      etime_reg[wptr_reg] <= stamp;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (clr) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      rptr_reg <= rptr_next;
      if (log_go) begin
        wptr_reg <= wptr_inc;
      end
    end
  end

  // filling wins over a read index write in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_reg <= 1'b0;
    end else if (clr) begin
      full_reg <= 1'b0;
    end else if (log_go && wptr_inc == rptr_next) begin
      full_reg <= 1'b1;
    end else if (ptr_wr && wdata[PTR_RD_LSB +: PTR_W] != rptr_reg) begin
      full_reg <= 1'b0;
    end
  end

  assign used = wptr_reg - rptr_reg;
  assign free_cnt = full_reg ? '0 : (DEPTH_CNT - {1'b0, used});
  assign ne_next = full_reg || used != '0;
  assign low_next = free_cnt <= {1'b0, wmark_reg};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ne_reg <= 1'b0;
      low_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      ne_reg <= ne_next;
      low_reg <= low_next;
      trig_reg <= ne_next && !ne_reg;
    end
  end

  assign ne_flag = ne_reg;
  assign low_flag = low_reg;
  assign full_flag = full_reg;
  assign seq_trig = trig_reg;
  assign wake_req = wake_reg && ne_reg && !core_on;

  always_comb begin
    rdata = '0;
    if (idx == OFF_CTRL) begin
      rdata[CTRL_ON_BIT] = on_reg;
      rdata[CTRL_WAKE_BIT] = wake_reg;
    end else if (idx == OFF_TSEL) begin
      rdata[1:0] = tsel_reg;
    end else if (idx == OFF_WMARK) begin
      rdata[PTR_W-1:0] = wmark_reg;
    end else if (idx == OFF_PTR) begin
      rdata[PTR_RD_LSB +: PTR_W] = rptr_reg;
      rdata[PTR_WR_LSB +: PTR_W] = wptr_reg;
      rdata[PTR_NE_BIT] = ne_reg;
      rdata[PTR_LOW_BIT] = low_reg;
      rdata[PTR_FULL_BIT] = full_reg;
    end else if (idx == OFF_CHEN) begin
      rdata[NCH-1:0] = chen_reg;
    end else if (idx >= OFF_CHDEF && idx <= OFF_CHDEF_END && !idx[0]) begin
      rdata[SEL_W-1:0] = csel_reg[idx[PTR_W:1]];
      rdata[DEF_POL_BIT] = cpol_reg[idx[PTR_W:1]];
      rdata[DEF_DB_BIT] = cdb_reg[idx[PTR_W:1]];
    end else if (idx >= OFF_ENTRY && idx <= OFF_ENTRY_END) begin
      if (idx[0]) begin
        rdata = etime_reg[idx[PTR_W:1]];
      end else begin
        rdata[SEL_W-1:0] = etag_reg[idx[PTR_W:1]];
        rdata[ENT_KIND_BIT] = ekind_reg[idx[PTR_W:1]];
      end
    end
  end

  one_grant_a : assert property ($onehot0(grant)) else $error("two channels granted");
  lowest_wins_a : assert property (log_go |-> (pend & (grant - NCH'(1))) == '0)
    else $error("higher channel logged before lower");
  full_blocks_a : assert property (full_reg && !clr |=> wptr_reg == $past(wptr_reg))
    else $error("write index moved while full");
  wptr_step_a : assert property (log_go && !clr |=> wptr_reg == $past(wptr_inc))
    else $error("write index did not advance");
  stamp_kept_a : assert property (log_go |=> etime_reg[$past(wptr_reg)] == $past(stamp))
    else $error("time stamp not stored");
  same_rptr_a : assert property (full_reg && ptr_wr && !clr &&
    wdata[PTR_RD_LSB +: PTR_W] == rptr_reg |=> full_reg) else $error("full cleared by same value");
  new_rptr_a : assert property (full_reg && ptr_wr && !clr &&
    wdata[PTR_RD_LSB +: PTR_W] != rptr_reg |=> !full_reg) else $error("full not released");
  clear_empty_a : assert property (clr |=> wptr_reg == '0 && rptr_reg == '0 && !full_reg
    ##1 !ne_reg && !low_reg) else $error("clear left state behind");
  ne_after_log_a : assert property (log_go && !ptr_wr |-> ##2 ne_reg)
    else $error("not-empty missed");
  full_low_a : assert property (full_reg |=> low_reg) else $error("watermark missed at full");
endmodule : eelog_core

module eelog_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [eelog_pkg::ADDR_W-1:0] ADDR,
  input wire logic [eelog_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  output logic [eelog_pkg::DATA_W-1:0] RDATA,
  input wire logic [eelog_pkg::SRC_NUM-1:0] EVENT_SRC,
  input wire logic CORE_CLK_ON,
  input wire logic [eelog_pkg::STAMP_W-1:0] TIMER1_VALUE,
  input wire logic [eelog_pkg::STAMP_W-1:0] TIMER2_VALUE,
  input wire logic TIMER1_TICK,
  input wire logic TIMER2_TICK,
  output logic [eelog_pkg::LOGGERS-1:0] HAS_UNREAD_FLAG,
  output logic [eelog_pkg::LOGGERS-1:0] LOW_SPACE_FLAG,
  output logic [eelog_pkg::LOGGERS-1:0] NO_SPACE_FLAG,
  output logic [eelog_pkg::LOGGERS-1:0] SEQ_TRIGGER,
  output logic [eelog_pkg::LOGGERS-1:0] CORE_WAKE
);
  import eelog_pkg::*;
  logic [SRC_NUM-1:0] src_meta_reg;
  logic [SRC_NUM-1:0] src_sync_reg;
  logic [DATA_W-1:0] rd_mux [LOGGERS];
  logic [LOGGERS-1:0] hit_inst;
  logic [DATA_W-1:0] rdata_reg;
  logic [ADDR_W-1:0] bases [LOGGERS];

  assign bases[0] = BASE_0;
  assign bases[1] = BASE_1;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      src_meta_reg <= EVENT_SRC;
      src_sync_reg <= src_meta_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LOGGERS; g++) begin : g_log
      assign hit_inst[g] = ADDR[ADDR_W-1:OFF_W] == bases[g][ADDR_W-1:OFF_W];
      eelog_core u_core (
        .clk(CLK),
        .rst_n(RST_N),
        .src(src_sync_reg),
        .core_on(CORE_CLK_ON),
        .timer1_value(TIMER1_VALUE),
        .timer2_value(TIMER2_VALUE),
        .timer1_tick(TIMER1_TICK),
        .timer2_tick(TIMER2_TICK),
        .wr_en(WR_STROBE && hit_inst[g]),
        .idx(ADDR[OFF_W-1:0]),
        .wdata(WDATA),
        .rdata(rd_mux[g]),
        .ne_flag(HAS_UNREAD_FLAG[g]),
        .low_flag(LOW_SPACE_FLAG[g]),
        .full_flag(NO_SPACE_FLAG[g]),
        .seq_trig(SEQ_TRIGGER[g]),
        .wake_req(CORE_WAKE[g])
      );
    end
  endgenerate

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= '0;
    end else if (RD_STROBE && hit_inst[0]) begin
      rdata_reg <= rd_mux[0];
    end else if (RD_STROBE && hit_inst[1]) begin
      rdata_reg <= rd_mux[1];
    end else begin
      rdata_reg <= '0;
    end
  end

  assign RDATA = rdata_reg;
endmodule : eelog_top
`default_nettype wire

/* hdl/eelog_pkg.sv */
// constants, register map and field layout of the edge event logger
package eelog_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int LOGGERS = 2;
  localparam int NCH = 16;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int SEL_W = 9;
  localparam int SRC_NUM = 32;
  localparam int SRC_W = 5;
  localparam int STAMP_W = 32;
  localparam int DB_W = 2;
  localparam int OFF_W = 8;
  // instance bases; register addresses are word indices, one 32-bit word each
  localparam logic [ADDR_W-1:0] BASE_0 = 20'h48000;
  localparam logic [ADDR_W-1:0] BASE_1 = 20'h48200;
  localparam logic [OFF_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [OFF_W-1:0] OFF_TSEL = 8'h04;
  localparam logic [OFF_W-1:0] OFF_WMARK = 8'h0c;
  localparam logic [OFF_W-1:0] OFF_PTR = 8'h0e;
  localparam logic [OFF_W-1:0] OFF_CHEN = 8'h20;
  localparam logic [OFF_W-1:0] OFF_CHDEF = 8'h40;
  localparam logic [OFF_W-1:0] OFF_CHDEF_END = 8'h5f;
  localparam logic [OFF_W-1:0] OFF_ENTRY = 8'h80;
  localparam logic [OFF_W-1:0] OFF_ENTRY_END = 8'h9f;
  // field positions
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_WAKE_BIT = 8;
  localparam int PTR_RD_LSB = 0;
  localparam int PTR_WR_LSB = 8;
  localparam int PTR_NE_BIT = 16;
  localparam int PTR_LOW_BIT = 17;
  localparam int PTR_FULL_BIT = 18;
  localparam int DEF_DB_BIT = 15;
  localparam int DEF_POL_BIT = 14;
  localparam int ENT_KIND_BIT = 15;
  // reset values and codes
  localparam logic [PTR_W-1:0] WMARK_RESET = 4'h1;
  localparam logic [1:0] TSEL_TIMER1 = 2'h0;
  localparam logic [1:0] TSEL_TIMER2 = 2'h1;
  localparam logic [SEL_W-1:0] SEL_LIMIT = 9'h020;
  localparam logic [DB_W-1:0] DB_LAST = 2'h3;
  localparam logic [PTR_W:0] DEPTH_CNT = 5'h10;
endpackage : eelog_pkg

/* tb/eelog_timer_model.sv */
// free-running timer pair standing in for the general-purpose timers
`timescale 1ns/10ps
`default_nettype none
module eelog_timer_model (
  input wire logic clk,
  input wire logic rst_n,
  output logic [31:0] t1_value,
  output logic [31:0] t2_value,
  output logic t1_tick,
  output logic t2_tick
);
  logic [2:0] div_reg;
  // timer 2 runs eight times slower so its value never exceeds timer 1's
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 3'h0;
      t1_value <= 32'h0;
      t2_value <= 32'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
      t1_value <= t1_value + 32'h1;
      if (div_reg == 3'h7) t2_value <= t2_value + 32'h1;
    end
  end
  assign t1_tick = (div_reg[1:0] == 2'h3);
  assign t2_tick = (div_reg == 3'h7);
endmodule : eelog_timer_model
`default_nettype wire

/* tb/edge_event_logger_test.sv */
// self-checking bench for the two-logger edge event block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module edge_event_logger_test;
  import eelog_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR_STROBE = 1'b0;
  logic RD_STROBE = 1'b0;
  logic [SRC_NUM-1:0] EVENT_SRC = '0;
  logic CORE_CLK_ON = 1'b1;
  logic [DATA_W-1:0] RDATA;
  logic [STAMP_W-1:0] t1v, t2v;
  logic t1k, t2k;
  logic [LOGGERS-1:0] ne, low, full, seq, wake;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] d, ta;
  always #2 CLK = ~CLK;
  eelog_timer_model tmr (.clk(CLK), .rst_n(RST_N), .t1_value(t1v), .t2_value(t2v),
    .t1_tick(t1k), .t2_tick(t2k));
  eelog_top uut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RDATA(RDATA), .EVENT_SRC(EVENT_SRC),
    .CORE_CLK_ON(CORE_CLK_ON), .TIMER1_VALUE(t1v), .TIMER2_VALUE(t2v), .TIMER1_TICK(t1k),
    .TIMER2_TICK(t2k), .HAS_UNREAD_FLAG(ne), .LOW_SPACE_FLAG(low), .NO_SPACE_FLAG(full),
    .SEQ_TRIGGER(seq), .CORE_WAKE(wake));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // a hang is cut short well beyond the longest scenario
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR_STROBE <= 1'b1;
    @(posedge CLK);
    WR_STROBE <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge CLK);
    ADDR <= a;
    RD_STROBE <= 1'b1;
    @(posedge CLK);
    RD_STROBE <= 1'b0;
    #1 v = RDATA;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask : idle
  task automatic pulse(input int s, input int n);
    @(posedge CLK);
    EVENT_SRC[s] <= 1'b1;
    idle(n);
    EVENT_SRC[s] <= 1'b0;
    idle(n);
  endtask : pulse
  task automatic t_reset_values;
    rd(20'h48000, d); `CHK("ctrl", 32'h0, d)
    rd(20'h4800c, d); `CHK("wmark", 32'h1, d)
    rd(20'h4800e, d); `CHK("ptr", 32'h0, d)
    rd(20'h480fe, d); `CHK("unmapped", 32'h0, d)
  endtask : t_reset_values
  task automatic t_initial_and_priority;
    int n;
    // channels stay off while their definitions are written
    wr(20'h48040, 32'h3);
    wr(20'h48042, 32'h7);
    wr(20'h48044, 32'h6);
    wr(20'h48046, 32'h4008);
    wr(20'h48048, 32'h9);
    wr(20'h48020, 32'h1f);
    wr(20'h48000, 32'h1);
    n = 0;
    while (ne[0] !== 1'b1 && n < 40) begin
      @(posedge CLK);
      #1 n++;
    end
    `CHK("seq trig", 1'b1, seq[0])
    rd(20'h48080, d); `CHK("entry0", 32'h8008, d)
    ta = t1v;
    pulse(3, 10);
    rd(20'h48083, d); `CHK("stamp", 1'b1, d > ta && d < ta + 32'd12)
    @(posedge CLK);
    EVENT_SRC[7:6] <= 2'h3;
    idle(12);
    EVENT_SRC[7:6] <= 2'h0;
    idle(12);
    rd(20'h48082, d); `CHK("entry1", 32'h3, d)
    rd(20'h48084, d); `CHK("entry2", 32'h7, d)
    rd(20'h48086, d); `CHK("entry3", 32'h6, d)
    rd(20'h4800e, d); `CHK("ptr4", 32'h10400, d)
  endtask : t_initial_and_priority
  task automatic t_fill_and_release;
    wr(20'h4800c, 32'h3);
    repeat (8) pulse(9, 6);
    rd(20'h4800e, d); `CHK("low off", 32'h10c00, d)
    pulse(9, 6);
    rd(20'h4800e, d); `CHK("low on", 32'h30d00, d)
    `CHK("low pin", 1'b1, low[0])
    repeat (4) pulse(9, 6);
    wr(20'h4800e, 32'h0);
    idle(4);
    rd(20'h4800e, d); `CHK("full hold", 32'h70000, d)
    `CHK("full pin", 1'b1, full[0])
    `CHK("other idle", 1'b0, ne[1])
    // the oldest entry would be the first one hit by a wrap
    rd(20'h48080, d); `CHK("no overwrite", 32'h8008, d)
    wr(20'h4800e, 32'h5);
    idle(4);
    `CHK("full off", 1'b0, full[0])
    pulse(9, 6);
    wr(20'h4800e, 32'h1);
    idle(4);
    rd(20'h4800e, d); `CHK("drained", 32'h101, d)
  endtask : t_fill_and_release
  task automatic t_clear;
    pulse(9, 6);
    wr(20'h48000, 32'h3);
    idle(4);
    rd(20'h4800e, d); `CHK("cleared", 32'h0, d)
    rd(20'h48000, d); `CHK("clr reads 0", 32'h1, d)
  endtask : t_clear
  task automatic t_debounce;
    // channel 5 is still off while its definition is written
    wr(20'h4804a, 32'h800b);
    wr(20'h48020, 32'h3f);
    pulse(11, 2);
    idle(4);
    rd(20'h4800e, d); `CHK("short glitch", 32'h0, d)
    pulse(11, 8);
    rd(20'h4800e, d); `CHK("held level", 32'h10100, d)
    rd(20'h48080, d); `CHK("debounced entry", 32'hb, d)
  endtask : t_debounce
  task automatic t_slow_clock;
    // timer source changes only with the logger off
    wr(20'h48204, 32'h1);
    wr(20'h48240, 32'ha);
    wr(20'h48220, 32'h1);
    @(posedge CLK);
    CORE_CLK_ON <= 1'b0;
    wr(20'h48200, 32'h101);
    ta = t2v;
    pulse(10, 60);
    rd(20'h48281, d); `CHK("timer2 stamp", 1'b1, d >= ta && d <= ta + 32'd16)
    rd(20'h4820e, d); `CHK("ptr l1", 32'h10100, d)
    `CHK("wake", 2'h2, wake)
    wr(20'h4820e, 32'h1);
    idle(40);
    `CHK("wake off", 2'h0, wake)
    @(posedge CLK);
    CORE_CLK_ON <= 1'b1;
  endtask : t_slow_clock
  initial begin
    idle(6);
    RST_N <= 1'b1;
    t_reset_values();
    t_initial_and_priority();
    t_fill_and_release();
    t_clear();
    t_debounce();
    t_slow_clock();
    wrap_up();
  end
endmodule : edge_event_logger_test
`default_nettype wire
